// ===== pkg/uafc_defines.svh
// register offsets, field values, defaults and line characters of the serial port block
// assumes a 32-bit apb slave with byte addresses in the low eight address bits
`ifndef UAFC_DEFINES_SVH
`define UAFC_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define UAFC_OFF_CFG_PEND 8'h00
`define UAFC_OFF_CFG_ACT 8'h04
`define UAFC_OFF_THR_PEND 8'h08
`define UAFC_OFF_THR_ACT 8'h0C
`define UAFC_OFF_COMMIT 8'h10
`define UAFC_OFF_ERR 8'h14
`define UAFC_OFF_TXDATA 8'h18
`define UAFC_OFF_RXDATA 8'h1C
`define UAFC_OFF_STATUS 8'h20
`define UAFC_OFF_QSEL 8'h24
`define UAFC_OFF_QRES 8'h28

// ****************************************************************
// rates, widths, thresholds, codes
// ****************************************************************
`define UAFC_RATE0 32'd300
`define UAFC_RATE1 32'd600
`define UAFC_RATE2 32'd1200
`define UAFC_RATE3 32'd2400
`define UAFC_RATE4 32'd4800
`define UAFC_RATE5 32'd9600
`define UAFC_RATE6 32'd19200
`define UAFC_BAUD_SEL_MAX 3'h6
`define UAFC_BAUD_SEL_DEF 3'h5
`define UAFC_BITS_MIN 4'h7
`define UAFC_BITS_MAX 4'h8
`define UAFC_THR_MIN 16'h0001
`define UAFC_START_DEF 16'h000A
`define UAFC_STOP_DEF 16'h0041
`define UAFC_CHAR_RESUME 8'h11
`define UAFC_CHAR_PAUSE 8'h13
`define UAFC_ERR_CODE 32'hFFFFFF22
`define UAFC_Q_CUR 2'h0
`define UAFC_Q_MAX 2'h1
`define UAFC_Q_MIN 2'h2
`define UAFC_ITEM_BAUD 2'h0
`define UAFC_ITEM_BITS 2'h1
`define UAFC_ITEM_START 2'h2
`define UAFC_ITEM_STOP 2'h3

`endif

// ===== pkg/uafc_pkg.sv
// types shared by the serial port configuration block
// assumes uafc_defines.svh for all numeric values
package uafc_pkg;

   typedef enum logic [1:0] {
      MODE_ON = 2'b00,
      MODE_OFF = 2'b01,
      MODE_MODEM = 2'b10,
      MODE_BUFFULL = 2'b11
   } uafc_mode_type;

   typedef enum logic [2:0] {
      PAR_NONE = 3'b000,
      PAR_EVEN = 3'b001,
      PAR_ODD = 3'b010,
      PAR_ZERO = 3'b011,
      PAR_ONE = 3'b100
   } uafc_parity_type;

   // bit 15 at the top: dtr[15:14] rts[13:12] receive_pacing[11] stop2[10] parity[9:7]
   // data_bits[6:3] baud[2:0]
   typedef struct packed {
      uafc_mode_type dtr_mode;
      uafc_mode_type rts_mode;
      logic receive_pacing;
      logic stop2;
      logic [2:0] parity;
      logic [3:0] data_bits;
      logic [2:0] baud;
   } uafc_cfg_type;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } uafc_tx_state_type;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } uafc_rx_state_type;

endpackage

// ===== core/uafc_serial_port.sv
// serial port with staged configuration, rts/dtr handshake modes and receive pacing
// assumes one 20 mhz clock, apb master, rxd/cts/dsr already synchronous to pclk
//
// Notes on behaviour
// - rts mode on holds the line high, off holds it low, whatever traffic
// - modem mode: rts high while output pending; send data only while cts high
// - buffer-full mode: rts high while fill below halt threshold, low at it
// - handshake settings take effect only when the commit write ends the message
// - cold boot puts rts mode to on
// - instrument reset leaves every serial setting untouched
// - baud defaults to 9600; range 300 to 19200
// - unsupported baud raises error -222 and the old rate stays
// - data width only 7 or 8; anything else is an error
// - 7 bits no parity 1 stop and 8 bits parity 2 stop are refused
// - cold boot sets 8 data bits
// - pacing sends pause at halt threshold, resume at resume threshold
// - resume character 0x11, pause character 0x13
// - cold boot turns receive pacing on
// - resume threshold accepts 1 up to the buffer capacity
// - thresholds act only under pacing or buffer-full mode
// - default thresholds 10 and 65 for the built-in size
// - max query of resume threshold returns buffer capacity
// - queries give current, max or min by qualifier
// - rts mode reads back as one of four codes
// - dtr has the same four modes; modem mode sends only while dsr high
// - cold boot: no parity, one stop bit, dtr on
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`include "uafc_defines.svh"

module uafc_serial_port import uafc_pkg::*; #(
   parameter int CLK_HZ = 20000000,
   parameter int BUF_DEPTH = 99,
   parameter int CNT_W = 17
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_reset,
   output logic txd,
   input wire logic rxd,
   output logic rts,
   output logic dtr,
   input wire logic cts,
   input wire logic dsr
);

   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (BUF_DEPTH < 1 || BUF_DEPTH > 8192) begin : g_bad_depth
      $error("buffer depth out of range");
   end
   if (CLK_HZ / 300 >= (1 << CNT_W) || CLK_HZ / 19200 < 4) begin : g_bad_clk
      $error("clock rate does not fit the bit counter");
   end

   typedef struct packed {
      uafc_cfg_type act;
      uafc_cfg_type pend;
      logic [15:0] act_start;
      logic [15:0] act_stop;
      logic [15:0] pend_start;
      logic [15:0] pend_stop;
      logic err;
      logic [3:0] qsel;
      logic [7:0] tx_hold;
      logic tx_full;
      uafc_tx_state_type tx_st;
      logic [7:0] tx_sh;
      logic tx_par;
      logic [3:0] tx_bit;
      logic [CNT_W-1:0] tx_cnt;
      logic txd;
      logic xon_req;
      logic xoff_req;
      logic paused;
      uafc_rx_state_type rx_st;
      logic [CNT_W-1:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic ovf;
      logic [BUF_DEPTH-1:0][7:0] mem;
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [15:0] fill;
      logic [31:0] prdata;
   } uafc_state_type;

   localparam uafc_cfg_type CFG_COLD = '{
      dtr_mode: MODE_ON,
      rts_mode: MODE_ON,
      receive_pacing: 1'b1,
      stop2: 1'b0,
      parity: PAR_NONE,
      data_bits: `UAFC_BITS_MAX,
      baud: `UAFC_BAUD_SEL_DEF
   };
   localparam logic [15:0] DEPTH16 = 16'(BUF_DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);

   uafc_state_type s_r;
   uafc_state_type s_nxt;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] rate_of(input logic [2:0] sel);
      case (sel)
         3'h0: rate_of = `UAFC_RATE0;
         3'h1: rate_of = `UAFC_RATE1;
         3'h2: rate_of = `UAFC_RATE2;
         3'h3: rate_of = `UAFC_RATE3;
         3'h4: rate_of = `UAFC_RATE4;
         3'h6: rate_of = `UAFC_RATE6;
         default: rate_of = `UAFC_RATE5;
      endcase
   endfunction

   // bit period in clocks; constant quotients only, no run-time divider
   function automatic logic [CNT_W-1:0] div_of(input logic [2:0] sel);
      case (sel)
         3'h0: div_of = CNT_W'(CLK_HZ / `UAFC_RATE0);
         3'h1: div_of = CNT_W'(CLK_HZ / `UAFC_RATE1);
         3'h2: div_of = CNT_W'(CLK_HZ / `UAFC_RATE2);
         3'h3: div_of = CNT_W'(CLK_HZ / `UAFC_RATE3);
         3'h4: div_of = CNT_W'(CLK_HZ / `UAFC_RATE4);
         3'h6: div_of = CNT_W'(CLK_HZ / `UAFC_RATE6);
         default: div_of = CNT_W'(CLK_HZ / `UAFC_RATE5);
      endcase
   endfunction

   // handshake line level for one of the four modes
   function automatic logic line_of(input uafc_mode_type m, input logic pending,
                                    input logic below_halt);
      case (m)
         MODE_ON: line_of = 1'b1;
         MODE_OFF: line_of = 1'b0;
         MODE_MODEM: line_of = pending;
         default: line_of = below_halt;
      endcase
   endfunction

   function automatic logic thr_ok(input logic [15:0] v);
      thr_ok = (v >= `UAFC_THR_MIN) && (v <= DEPTH16);
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      if (a == `UAFC_OFF_CFG_PEND) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_CFG_ACT) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_THR_PEND) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_THR_ACT) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_COMMIT) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_ERR) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_TXDATA) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_RXDATA) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_STATUS) addr_ok = 1'b1;
      else if (a == `UAFC_OFF_QSEL) addr_ok = 1'b1;
      else addr_ok = (a == `UAFC_OFF_QRES);
   endfunction

   // ****************************************************************
   // combinational view of the current state
   // ****************************************************************
   logic [CNT_W-1:0] div;
   logic tx_tick;
   logic rx_mid;
   logic rx_tick;
   logic flow_ok;
   logic tx_pending;
   logic below_halt;
   logic access;
   logic [3:0] last_bit;
   logic [7:0] tx_mask;
   logic [31:0] qres;

   always_comb begin
      div = div_of(s_r.act.baud);
      tx_tick = (s_r.tx_cnt == div - CNT_W'(1));
      rx_tick = (s_r.rx_cnt == div - CNT_W'(1));
      rx_mid = (s_r.rx_cnt == (div >> 1));
      flow_ok = (s_r.act.rts_mode != MODE_MODEM || cts)
             && (s_r.act.dtr_mode != MODE_MODEM || dsr);
      tx_pending = s_r.tx_full || (s_r.tx_st != TX_IDLE);
      below_halt = (s_r.fill < s_r.act_stop);
      access = psel && penable;
      last_bit = s_r.act.data_bits - 4'h1;
      tx_mask = (s_r.act.data_bits == `UAFC_BITS_MIN) ? 8'h7F : 8'hFF;
   end

   // query result: current, max or min of one setting
   always_comb begin
      qres = 32'h00000000;
      case (s_r.qsel[1:0])
         `UAFC_ITEM_BAUD: begin
            if (s_r.qsel[3:2] == `UAFC_Q_MAX) qres = `UAFC_RATE6;
            else if (s_r.qsel[3:2] == `UAFC_Q_MIN) qres = `UAFC_RATE0;
            else qres = rate_of(s_r.act.baud);
         end
         `UAFC_ITEM_BITS: begin
            if (s_r.qsel[3:2] == `UAFC_Q_MAX) qres = 32'(`UAFC_BITS_MAX);
            else if (s_r.qsel[3:2] == `UAFC_Q_MIN) qres = 32'(`UAFC_BITS_MIN);
            else qres = 32'(s_r.act.data_bits);
         end
         default: begin
            if (s_r.qsel[3:2] == `UAFC_Q_MAX) qres = 32'(DEPTH16);
            else if (s_r.qsel[3:2] == `UAFC_Q_MIN) qres = 32'(`UAFC_THR_MIN);
            else if (s_r.qsel[1:0] == `UAFC_ITEM_START) qres = 32'(s_r.act_start);
            else qres = 32'(s_r.act_stop);
         end
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic baud_ok;
      logic frame_ok;
      logic push;
      logic pop;
      logic [7:0] rx_byte;
      baud_ok = 1'b0;
      frame_ok = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      rx_byte = 8'h00;
      s_nxt = s_r;
      pready = !(access && pwrite && paddr == `UAFC_OFF_TXDATA && s_r.tx_full);
      pslverr = access && !addr_ok(paddr);

      // transmitter; pacing characters bypass cts/dsr so a pause always goes out
      if (s_r.tx_st != TX_IDLE) begin
         s_nxt.tx_cnt = tx_tick ? '0 : s_r.tx_cnt + CNT_W'(1);
      end
      case (s_r.tx_st)
         TX_IDLE: begin
            s_nxt.txd = 1'b1;
            s_nxt.tx_cnt = '0;
            if (s_r.xoff_req || s_r.xon_req) begin
               s_nxt.tx_sh = s_r.xoff_req ? `UAFC_CHAR_PAUSE : `UAFC_CHAR_RESUME;
               s_nxt.xoff_req = 1'b0;
               s_nxt.xon_req = 1'b0;
               s_nxt.tx_st = TX_START;
               s_nxt.txd = 1'b0;
            end else if (s_r.tx_full && flow_ok) begin
               s_nxt.tx_sh = s_r.tx_hold & tx_mask;
               s_nxt.tx_full = 1'b0;
               s_nxt.tx_st = TX_START;
               s_nxt.txd = 1'b0;
            end
         end
         TX_START: begin
            if (tx_tick) begin
               s_nxt.tx_st = TX_DATA;
               s_nxt.tx_bit = 4'h0;
               s_nxt.txd = s_r.tx_sh[0];
               case (uafc_parity_type'(s_r.act.parity))
                  PAR_EVEN: s_nxt.tx_par = ^s_r.tx_sh;
                  PAR_ODD: s_nxt.tx_par = ~^s_r.tx_sh;
                  PAR_ONE: s_nxt.tx_par = 1'b1;
                  default: s_nxt.tx_par = 1'b0;
               endcase
            end
         end
         TX_DATA: begin
            if (tx_tick) begin
               s_nxt.tx_sh = s_r.tx_sh >> 1;
               s_nxt.tx_bit = s_r.tx_bit + 4'h1;
               s_nxt.txd = s_r.tx_sh[1];
               if (s_r.tx_bit == last_bit) begin
                  s_nxt.tx_bit = 4'h0;
                  if (s_r.act.parity != PAR_NONE) begin
                     s_nxt.tx_st = TX_PAR;
                     s_nxt.txd = s_r.tx_par;
                  end else begin
                     s_nxt.tx_st = TX_STOP;
                     s_nxt.txd = 1'b1;
                  end
               end
            end
         end
         TX_PAR: begin
            if (tx_tick) begin
               s_nxt.tx_st = TX_STOP;
               s_nxt.txd = 1'b1;
            end
         end
         default: begin
            if (tx_tick) begin
               if (s_r.act.stop2 && s_r.tx_bit == 4'h0) begin
                  s_nxt.tx_bit = 4'h1;
               end else begin
                  s_nxt.tx_st = TX_IDLE;
               end
            end
         end
      endcase

      // receiver samples each bit at its middle
      s_nxt.rx_cnt = (rx_tick || s_r.rx_st == RX_IDLE) ? '0 : s_r.rx_cnt + CNT_W'(1);
      case (s_r.rx_st)
         RX_IDLE: begin
            if (!rxd) s_nxt.rx_st = RX_START;
         end
         RX_START: begin
            if (rx_mid) begin
               s_nxt.rx_cnt = '0;
               s_nxt.rx_bit = 4'h0;
               s_nxt.rx_st = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               s_nxt.rx_sh = {rxd, s_r.rx_sh[7:1]};
               s_nxt.rx_bit = s_r.rx_bit + 4'h1;
               if (s_r.rx_bit == last_bit) begin
                  s_nxt.rx_st = (s_r.act.parity != PAR_NONE) ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (rx_tick) s_nxt.rx_st = RX_STOP;
         end
         default: begin
            if (rx_tick) begin
               s_nxt.rx_st = RX_IDLE;
               rx_byte = (s_r.act.data_bits == `UAFC_BITS_MIN) ? {1'b0, s_r.rx_sh[7:1]}
                                                              : s_r.rx_sh;
               if (rxd && s_r.fill < DEPTH16) push = 1'b1;
               else if (rxd) s_nxt.ovf = 1'b1;
            end
         end
      endcase

      // apb: read data latched in the setup cycle, effects at the completing edge
      if (psel && !penable) begin
         if (paddr == `UAFC_OFF_CFG_PEND) s_nxt.prdata = 32'(s_r.pend);
         else if (paddr == `UAFC_OFF_CFG_ACT) s_nxt.prdata = 32'(s_r.act);
         else if (paddr == `UAFC_OFF_THR_PEND) s_nxt.prdata = {s_r.pend_stop, s_r.pend_start};
         else if (paddr == `UAFC_OFF_THR_ACT) s_nxt.prdata = {s_r.act_stop, s_r.act_start};
         else if (paddr == `UAFC_OFF_ERR) s_nxt.prdata = s_r.err ? `UAFC_ERR_CODE : '0;
         else if (paddr == `UAFC_OFF_RXDATA) s_nxt.prdata = {23'h0, s_r.fill != 16'h0,
                                                            s_r.mem[s_r.rptr]};
         else if (paddr == `UAFC_OFF_STATUS) s_nxt.prdata = {11'h0, s_r.paused, s_r.ovf,
                                                            tx_pending, dtr, rts, s_r.fill};
         else if (paddr == `UAFC_OFF_QSEL) s_nxt.prdata = {28'h0, s_r.qsel};
         else if (paddr == `UAFC_OFF_QRES) s_nxt.prdata = qres;
         else s_nxt.prdata = '0;
      end
      if (access && pready && !pwrite && paddr == `UAFC_OFF_RXDATA && s_r.fill != 16'h0) begin
         pop = 1'b1;
      end
      if (access && pready && pwrite) begin
         if (paddr == `UAFC_OFF_CFG_PEND) begin
            s_nxt.pend = uafc_cfg_type'(pwdata[15:0]);
         end else if (paddr == `UAFC_OFF_THR_PEND) begin
            s_nxt.pend_start = pwdata[15:0];
            s_nxt.pend_stop = pwdata[31:16];
         end else if (paddr == `UAFC_OFF_ERR) begin
            s_nxt.err = 1'b0;
         end else if (paddr == `UAFC_OFF_TXDATA) begin
            s_nxt.tx_hold = pwdata[7:0];
            s_nxt.tx_full = 1'b1;
         end else if (paddr == `UAFC_OFF_QSEL) begin
            s_nxt.qsel = pwdata[3:0];
         end else if (paddr == `UAFC_OFF_COMMIT) begin
            // end of message: staged settings go live, bad groups keep the old value
            baud_ok = (s_r.pend.baud <= `UAFC_BAUD_SEL_MAX);
            frame_ok = (s_r.pend.data_bits == `UAFC_BITS_MIN
                     || s_r.pend.data_bits == `UAFC_BITS_MAX)
                     && (s_r.pend.parity <= PAR_ONE)
                     && !(s_r.pend.data_bits == `UAFC_BITS_MIN
                          && s_r.pend.parity == PAR_NONE && !s_r.pend.stop2)
                     && !(s_r.pend.data_bits == `UAFC_BITS_MAX
                          && s_r.pend.parity != PAR_NONE && s_r.pend.stop2);
            s_nxt.act.rts_mode = s_r.pend.rts_mode;
            s_nxt.act.dtr_mode = s_r.pend.dtr_mode;
            s_nxt.act.receive_pacing = s_r.pend.receive_pacing;
            if (baud_ok) s_nxt.act.baud = s_r.pend.baud;
            if (frame_ok) begin
               s_nxt.act.data_bits = s_r.pend.data_bits;
               s_nxt.act.parity = s_r.pend.parity;
               s_nxt.act.stop2 = s_r.pend.stop2;
            end
            if (thr_ok(s_r.pend_start) && thr_ok(s_r.pend_stop)) begin
               s_nxt.act_start = s_r.pend_start;
               s_nxt.act_stop = s_r.pend_stop;
            end
            // error is set here; a clear is a separate error-register write, so set and clear never fall in one cycle
            if (!baud_ok || !frame_ok || !thr_ok(s_r.pend_start) || !thr_ok(s_r.pend_stop)) begin
               s_nxt.err = 1'b1;
            end
         end
      end

      // receive buffer
      if (push) begin
         s_nxt.mem[s_r.wptr] = rx_byte;
         s_nxt.wptr = (s_r.wptr == PTR_LAST) ? '0 : s_r.wptr + PTR_W'(1);
      end
      if (pop) s_nxt.rptr = (s_r.rptr == PTR_LAST) ? '0 : s_r.rptr + PTR_W'(1);
      s_nxt.fill = s_r.fill + {15'h0, push} - {15'h0, pop};

      // receive pacing on the buffer fill
      if (!s_r.act.receive_pacing) begin
         s_nxt.paused = 1'b0;
         s_nxt.xoff_req = 1'b0;
         s_nxt.xon_req = 1'b0;
      end else if (!s_r.paused && s_r.fill >= s_r.act_stop) begin
         s_nxt.paused = 1'b1;
         s_nxt.xoff_req = 1'b1;
         s_nxt.xon_req = 1'b0;
      end else if (s_r.paused && s_r.fill <= s_r.act_start) begin
         s_nxt.paused = 1'b0;
         s_nxt.xon_req = 1'b1;
         s_nxt.xoff_req = 1'b0;
      end

      // instrument reset clears traffic only; settings stay as they are
      if (instr_reset) begin
         s_nxt.tx_st = TX_IDLE;
         s_nxt.txd = 1'b1;
         s_nxt.tx_full = 1'b0;
         s_nxt.xon_req = 1'b0;
         s_nxt.xoff_req = 1'b0;
         s_nxt.paused = 1'b0;
         s_nxt.rx_st = RX_IDLE;
         s_nxt.wptr = '0;
         s_nxt.rptr = '0;
         s_nxt.fill = '0;
         s_nxt.ovf = 1'b0;
      end
   end

   // ****************************************************************
   // state register; presetn is the cold boot
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.act <= CFG_COLD;
         s_r.pend <= CFG_COLD;
         s_r.act_start <= `UAFC_START_DEF;
         s_r.act_stop <= `UAFC_STOP_DEF;
         s_r.pend_start <= `UAFC_START_DEF;
         s_r.pend_stop <= `UAFC_STOP_DEF;
         s_r.txd <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      prdata = s_r.prdata;
      txd = s_r.txd;
      rts = line_of(s_r.act.rts_mode, tx_pending, below_halt);
      dtr = line_of(s_r.act.dtr_mode, tx_pending, below_halt);
   end

endmodule

// ===== tb/uafc_chk_sva.sv
// checker of the handshake lines and apb answers
// assumes only the ports of the serial port core
`timescale 1ns/100ps
module uafc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instr_reset,
   input wire logic rts,
   input wire logic dtr,
   input wire logic txd,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata
);
   logic [3:0] pend_r;
   logic [3:0] act_r;
   wire logic wr = psel && penable && pready && pwrite;
   // shadow of staged and applied line modes, so all but the boot, ready and slave error checks are gated on the applied on, off or modem mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 4'h0;
         act_r <= 4'h0;
      end else begin
         if (wr && paddr == 8'h00) pend_r <= pwdata[15:12];
         if (wr && paddr == 8'h10) act_r <= pend_r;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_on; act_r[1:0] == 2'h0 |-> rts; endproperty
   a_on: assert property (p_on) else $error("rts low");
   property p_off; act_r[1:0] == 2'h1 |-> !rts; endproperty
   a_off: assert property (p_off) else $error("rts high");
   property p_dtr; !act_r[3] |-> dtr == !act_r[2]; endproperty
   a_dtr: assert property (p_dtr) else $error("dtr wrong");
   property p_boot; $rose(presetn) |-> rts && dtr; endproperty
   a_boot: assert property (p_boot) else $error("lines after boot");
   property p_irst; instr_reset && act_r[1:0] == 2'h1 |=> !rts [*2]; endproperty
   a_irst: assert property (p_irst) else $error("mode lost");
   property p_stage; wr && paddr == 8'h00 && !act_r[1] |=> $stable(rts); endproperty
   a_stage: assert property (p_stage) else $error("staged early");
   property p_rdy; psel && penable && paddr != 8'h18 |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state");
   property p_err; psel && penable |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0); endproperty
   a_err: assert property (p_err) else $error("slave error");
   property p_mdm; act_r == 4'hA && !txd |-> rts && dtr; endproperty
   a_mdm: assert property (p_mdm) else $error("line low while sending");
endmodule

// ===== tb/uafc_term.sv
// terminal model: sends 8n1 frames on rxd, decodes frames from txd
// assumes the block runs 8 data bits, no parity, at BIT clocks per bit
`timescale 1ns/100ps
module uafc_term #(parameter int BIT = 20) (
   input wire logic pclk,
   input wire logic txd,
   output logic rxd = 1'b1,
   output logic cts = 1'b1,
   output logic dsr = 1'b1,
   output logic [7:0] rx_byte = 8'h00,
   output logic rx_stb = 1'b0
);
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (BIT) @(posedge pclk);
      end
   endtask
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge pclk);
         rx_byte[i] <= txd;
      end
      repeat (BIT) @(posedge pclk);
      rx_stb <= 1'b1;
      @(posedge pclk);
      rx_stb <= 1'b0;
   end
endmodule

// ===== tb/test_uafc_serial_port.sv
// bench: apb traffic and pacing against the terminal model
// assumes the terminal bit period of 20 clocks, i.e. 9600 at CLK_HZ 192000
`timescale 1ns/100ps
module test_uafc_serial_port;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_reset = 0;
   logic pready, pslverr, txd, rxd, rts, dtr, cts, dsr, rx_stb;
   logic [7:0] paddr = 8'h00, rx_byte, c;
   logic [2:0] b;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [31:0] exp_q[$];
   logic [3:0] qs[4] = '{4'h0, 4'h4, 4'h9, 4'h6};
   logic [31:0] qv[4] = '{32'h2580, 32'h4B00, 32'h7, 32'h63};
   int failures = 0, tests_run = 0;
   uafc_serial_port #(.CLK_HZ(192000)) dut_u(.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_reset(instr_reset), .txd(txd), .rxd(rxd),
      .rts(rts), .dtr(dtr), .cts(cts), .dsr(dsr));
   uafc_term term_u(.pclk(pclk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr),
      .rx_byte(rx_byte), .rx_stb(rx_stb));
   initial forever #25 pclk = ~pclk;
   task summarize;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic x(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      if (n >= 200) failures++;
      if (n >= 200) summarize;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      x(a, 1'b0, 32'h0);
   endtask
   task automatic drain;
      for (int n = 0; exp_q.size() > 0; n++) begin
         if (n > 3000) failures++;
         if (n > 3000) summarize;
         @(posedge pclk);
      end
   endtask
   always @(posedge pclk) if ((psel && penable && pready && !pwrite) || rx_stb) begin
      q = rx_stb ? {24'h0, rx_byte} : prdata;
      tests_run++;
      if (exp_q.size() == 0 || exp_q[0] !== q) begin
         failures++;
         $display("MISMATCH %0t got %h", $time, q);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
   end
   initial begin
      void'($urandom(95892));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      r(8'h04, 32'h0845);
      r(8'h0C, 32'h0041000A);
      for (int i = 0; i < 4; i++) begin
         x(8'h24, 1'b1, {28'h0, qs[i]});
         r(8'h28, qv[i]);
      end
      b = 3'($urandom_range(6, 0));
      x(8'h00, 1'b1, {16'h0, 13'h0318, b});
      r(8'h04, 32'h0845);
      x(8'h10, 1'b1, 32'h0);
      r(8'h04, {16'h0, 13'h0318, b});
      instr_reset <= 1'b1;
      @(posedge pclk);
      instr_reset <= 1'b0;
      x(8'h00, 1'b1, 32'h18C7);
      x(8'h10, 1'b1, 32'h0);
      r(8'h14, 32'hFFFFFF22);
      r(8'h04, {16'h0, 13'h0318, b});
      x(8'h14, 1'b1, 32'h0);
      x(8'h00, 1'b1, 32'h483D);
      x(8'h10, 1'b1, 32'h0);
      r(8'h14, 32'hFFFFFF22);
      r(8'h04, 32'h48C5);
      x(8'h00, 1'b1, 32'h3845);
      x(8'h08, 1'b1, 32'h00030001);
      x(8'h10, 1'b1, 32'h0);
      x(8'h14, 1'b1, 32'h0);
      r(8'h14, 32'h0);
      r(8'h2C, 32'h0);
      c = 8'($urandom);
      exp_q.push_back(32'h13);
      repeat (3) term_u.send(c);
      drain;
      repeat (40) @(posedge pclk);
      r(8'h20, 32'h00120003);
      r(8'h1C, {23'h0, 1'b1, c});
      r(8'h1C, {23'h0, 1'b1, c});
      exp_q.push_back(32'h11);
      drain;
      x(8'h00, 1'b1, 32'hA845);
      x(8'h10, 1'b1, 32'h0);
      exp_q.push_back({24'h0, c});
      x(8'h18, 1'b1, {24'h0, c});
      drain;
      summarize;
   end
endmodule
bind uafc_serial_port uafc_chk chk_u(.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .instr_reset(instr_reset), .rts(rts), .dtr(dtr), .txd(txd), .paddr(paddr),
   .pwdata(pwdata));
